// ==== core/osc_source_pll_select.sv ====
// Behaviour
// - fast osc postscale 3-bit field, factors up to 1:256
// - power-on source from initial source and primary submode config fields
// - unprogrammed config (111) starts in selectable fast osc postscale mode
// - instruction clock is selected oscillator clock divided by two
// - pll input divided by prescale factor 2..33 before vco
// - vco multiplied by 9-bit feedback factor; software keeps 100-200 MHz
// - vco divided by 2,4,8 from 2-bit field; software keeps 12.5-80 MHz
// - pll output equals input times multiplier over prescale times postscale
// - non-primary source codes decode regardless of submode
// - primary codes use submode: 10 hs crystal, 01 crystal, 00 external
// - current source readable at bits 14:12, same encoding
// - next source writable at 10:8 when config is switch-only, loaded from config at reset
// - freeze bit 7 locks source when config is switch-only
// - pin select freeze bit 6 blocks pin select writes
// - lock bit 5 high only once lock timer expired, no lock detect
// - clock fail flag set by monitor, sticky, software clears
// - bits 15, 11, 4, 2 read zero, writes ignored
// - slow internal osc feeds watchdog and fail monitor
// - prescale code plus two, reset code zero
// - feedback code plus two, 2..513, reset multiplier 50
// - output divider 00 /2, 01 /4 reset, 10 reserved, 11 /8
// - fast osc postscale codes give 1,2,4,8,16,32,64,256
//
// The placing of the registers and strobed register access were left to the implementer.
`default_nettype none
module osc_source_pll_select #(
	parameter int LOCK_CYCLES = osc_pkg::LOCK_WAIT_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [2:0]  initial_source_select_i,
	input  wire logic [1:0]  primary_submode_select_i,
	input  wire logic [1:0]  switch_monitor_config_i,
	input  wire logic        fast_internal_osc_i,
	input  wire logic        slow_internal_osc_i,
	input  wire logic        primary_osc_i,
	input  wire logic        low_power_crystal_osc_i,
	input  wire logic        pll_vco_i,
	input  wire logic        clock_fail_monitor_i,
	input  wire logic [1:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic        pin_select_wr_i,
	output logic [15:0] reg_rdata_o,
	output logic        pin_select_wr_ok_o,
	output logic        instr_clk_en_o,
	output logic        osc_clk_en_o,
	output logic        ref_clk_o,
	output logic [2:0]  active_source_o,
	output logic [1:0]  active_submode_o,
	output logic [4:0]  pll_prescale_code_o,
	output logic [8:0]  pll_multiplier_code_o,
	output logic [1:0]  pll_postscale_code_o
);
	// external oscillator pins are asynchronous: two flops before use
	logic [1:0] frc_s_r, slow_internal_osc_s_r, pri_s_r, lpx_s_r, vco_s_r, fail_s_r;
	always_ff @(posedge clk_i) begin
		frc_s_r  <= {frc_s_r[0],  fast_internal_osc_i};
		slow_internal_osc_s_r <= {slow_internal_osc_s_r[0], slow_internal_osc_i};
		pri_s_r  <= {pri_s_r[0],  primary_osc_i};
		lpx_s_r  <= {lpx_s_r[0],  low_power_crystal_osc_i};
		vco_s_r  <= {vco_s_r[0],  pll_vco_i};
		fail_s_r <= {fail_s_r[0], clock_fail_monitor_i};
	end

	logic frc_d_r, slow_internal_osc_d_r, pri_d_r, lpx_d_r, vco_d_r;
	always_ff @(posedge clk_i) begin
		frc_d_r  <= frc_s_r[1];
		slow_internal_osc_d_r <= slow_internal_osc_s_r[1];
		pri_d_r  <= pri_s_r[1];
		lpx_d_r  <= lpx_s_r[1];
		vco_d_r  <= vco_s_r[1];
	end
	logic frc_rise, slow_internal_osc_rise, pri_rise, lpx_rise, vco_rise;
	assign frc_rise  = frc_s_r[1]  & ~frc_d_r;
	assign slow_internal_osc_rise = slow_internal_osc_s_r[1] & ~slow_internal_osc_d_r;
	assign pri_rise  = pri_s_r[1]  & ~pri_d_r;
	assign lpx_rise  = lpx_s_r[1]  & ~lpx_d_r;
	assign vco_rise  = vco_s_r[1]  & ~vco_d_r;

	// config capture is clocked, after reset release
	logic [2:0] cur_src_r;
	logic [1:0] submode_r;
	logic [2:0] next_src_r;
	logic       cfg_load_r;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_load_r <= 1'b1;
		end else begin
			cfg_load_r <= 1'b0;
		end
	end

	logic wr_osc, wr_div, wr_fb;
	assign wr_osc = reg_wr_i && reg_addr_i == osc_pkg::ADDR_OSC_CTRL;
	assign wr_div = reg_wr_i && reg_addr_i == osc_pkg::ADDR_CLK_DIV;
	assign wr_fb  = reg_wr_i && reg_addr_i == osc_pkg::ADDR_FB_DIV;

	logic freeze_r, pinsel_r, lpen_r, swen_r;
	logic switch_ok;
	assign switch_ok = switch_monitor_config_i == osc_pkg::SWMON_SWITCH_ONLY && !freeze_r;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			freeze_r <= 1'b0;
			pinsel_r <= 1'b0;
			lpen_r   <= 1'b0;
		end else if (wr_osc) begin
			freeze_r <= reg_wdata_i[osc_pkg::FREEZE_BIT];
			pinsel_r <= reg_wdata_i[osc_pkg::PINSEL_BIT];
			lpen_r   <= reg_wdata_i[osc_pkg::LPEN_BIT];
		end
	end

	// simple switch: settle a few cycles then adopt next source
	logic [3:0] settle_r;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			swen_r   <= 1'b0;
			settle_r <= 4'h0;
		end else if (cfg_load_r) begin
			swen_r   <= 1'b0;
			settle_r <= 4'h0;
		end else if (swen_r) begin
			if (next_src_r == cur_src_r || settle_r == 4'(osc_pkg::SWITCH_SETTLE - 1)) begin
				swen_r   <= 1'b0;
				settle_r <= 4'h0;
			end else begin
				settle_r <= settle_r + 4'h1;
			end
		end else if (wr_osc && reg_wdata_i[osc_pkg::SWEN_BIT] && switch_ok) begin
			swen_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cur_src_r  <= osc_pkg::SRC_FRCN;
			next_src_r <= osc_pkg::SRC_FRCN;
			submode_r  <= osc_pkg::SUB_EC;
		end else if (cfg_load_r) begin
			cur_src_r  <= initial_source_select_i;
			next_src_r <= initial_source_select_i;
			submode_r  <= primary_submode_select_i;
		end else begin
			if (wr_osc && switch_ok && !swen_r) begin
				next_src_r <= reg_wdata_i[osc_pkg::NEXT_SRC_LSB +: 3];
			end
			if (swen_r && settle_r == 4'(osc_pkg::SWITCH_SETTLE - 1)) begin
				cur_src_r <= next_src_r;
			end
		end
	end

	logic is_pll;
	assign is_pll = cur_src_r == osc_pkg::SRC_FRC_PLL || cur_src_r == osc_pkg::SRC_PRI_PLL;

	// divider fields
	logic [2:0] frc_post_r;
	logic [1:0] pll_post_r;
	logic [4:0] pll_pre_r;
	logic [8:0] pll_fb_r;
	logic       lock_r;
	logic       div_hold;
	assign div_hold = is_pll && !lock_r;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			frc_post_r <= osc_pkg::FRC_POST_RST;
			pll_post_r <= osc_pkg::PLL_POST_RST;
			pll_pre_r  <= osc_pkg::PLL_PRE_RST;
		end else if (wr_div) begin
			frc_post_r <= reg_wdata_i[osc_pkg::FRCDIV_LSB +: 3];
			if (!div_hold) begin
				pll_post_r <= reg_wdata_i[osc_pkg::POSTDIV_LSB +: 2];
				pll_pre_r  <= reg_wdata_i[osc_pkg::PREDIV_LSB +: 5];
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pll_fb_r <= osc_pkg::PLL_FB_RST;
		end else if (wr_fb && !div_hold) begin
			pll_fb_r <= reg_wdata_i[8:0];
		end
	end

	// pll stages: input prescale, then vco edges divided by postscale
	logic [5:0] pre_cnt_r;
	logic       pll_in_rise;
	logic [5:0] pre_div;
	assign pre_div = {1'b0, pll_pre_r} + 6'h2;
	assign pll_in_rise = cur_src_r == osc_pkg::SRC_FRC_PLL ? frc_rise : pri_rise;
	logic pd_tick;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !is_pll) begin
			pre_cnt_r <= 6'h0;
			pd_tick   <= 1'b0;
		end else begin
			pd_tick <= 1'b0;
			if (pll_in_rise) begin
				if (pre_cnt_r == pre_div - 6'h1) begin
					pre_cnt_r <= 6'h0;
					pd_tick   <= 1'b1;
				end else begin
					pre_cnt_r <= pre_cnt_r + 6'h1;
				end
			end
		end
	end

	logic [2:0] post_cnt_r;
	logic [2:0] post_max;
	always_comb begin
		unique case (pll_post_r)
			2'h0:    post_max = 3'h1;
			2'h1:    post_max = 3'h3;
			2'h3:    post_max = 3'h7;
			default: post_max = 3'h3; // reserved code keeps /4
		endcase
	end
	logic pll_out_tick;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !is_pll) begin
			post_cnt_r   <= 3'h0;
			pll_out_tick <= 1'b0;
		end else begin
			pll_out_tick <= 1'b0;
			if (vco_rise) begin
				if (post_cnt_r >= post_max) begin
					post_cnt_r   <= 3'h0;
					pll_out_tick <= 1'b1;
				end else begin
					post_cnt_r <= post_cnt_r + 3'h1;
				end
			end
		end
	end

	// lock: start-up timer counts from pll selection, reset when pll is deselected
	logic [$clog2(LOCK_CYCLES + 1)-1:0] lock_cnt_r;
	logic                               pd_seen_r;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !is_pll || cfg_load_r) begin
			lock_cnt_r <= '0;
			lock_r     <= 1'b0;
			pd_seen_r  <= 1'b0;
		end else if (!lock_r) begin
			if (pd_tick) begin
				pd_seen_r <= 1'b1;
			end
			if (lock_cnt_r == ($clog2(LOCK_CYCLES + 1))'(LOCK_CYCLES - 1)) begin
				lock_r <= 1'b1;
			end else begin
				lock_cnt_r <= lock_cnt_r + 1'b1;
			end
		end
	end

	// fast osc postscale counter, /16 mode shares it
	logic [7:0] frc_cnt_r;
	logic [7:0] frc_mask;
	always_comb begin
		unique case (frc_post_r)
			3'h7:    frc_mask = 8'hFF;
			default: frc_mask = 8'((9'h001 << frc_post_r) - 9'h001);
		endcase
		if (cur_src_r == osc_pkg::SRC_FRC16) begin
			frc_mask = 8'((9'h001 << osc_pkg::FRC16_SHIFT) - 9'h001);
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			frc_cnt_r <= 8'h00;
		end else if (frc_rise) begin
			frc_cnt_r <= (frc_cnt_r & frc_mask) == frc_mask ? 8'h00 : frc_cnt_r + 8'h01;
		end
	end
	logic frc_div_tick;
	assign frc_div_tick = frc_rise && (frc_cnt_r & frc_mask) == frc_mask;

	logic osc_tick;
	always_comb begin
		unique case (cur_src_r)
			osc_pkg::SRC_FRC:     osc_tick = frc_rise;
			osc_pkg::SRC_PRI:     osc_tick = pri_rise;
			osc_pkg::SRC_LPXTAL:  osc_tick = lpx_rise;
			osc_pkg::SRC_SLOW_INTERNAL_OSC:    osc_tick = slow_internal_osc_rise;
			osc_pkg::SRC_FRC16:   osc_tick = frc_div_tick;
			osc_pkg::SRC_FRCN:    osc_tick = frc_div_tick;
			default:              osc_tick = pll_out_tick & lock_r;
		endcase
	end

	logic half_r;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			half_r         <= 1'b0;
			osc_clk_en_o   <= 1'b0;
			instr_clk_en_o <= 1'b0;
		end else begin
			osc_clk_en_o   <= osc_tick;
			instr_clk_en_o <= osc_tick & half_r;
			if (osc_tick) begin
				half_r <= ~half_r;
			end
		end
	end

	// fail flag: set wins over software clear
	logic fail_r;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fail_r <= 1'b0;
		end else if (fail_s_r[1]) begin
			fail_r <= 1'b1;
		end else if (wr_osc && !reg_wdata_i[osc_pkg::FAIL_BIT]) begin
			fail_r <= 1'b0;
		end
	end

	logic [15:0] osc_word;
	always_comb begin
		osc_word = 16'h0000;
		osc_word[osc_pkg::CUR_SRC_LSB +: 3]  = cur_src_r;
		osc_word[osc_pkg::NEXT_SRC_LSB +: 3] = next_src_r;
		osc_word[osc_pkg::FREEZE_BIT]        = freeze_r;
		osc_word[osc_pkg::PINSEL_BIT]        = pinsel_r;
		osc_word[osc_pkg::LOCK_BIT]          = lock_r;
		osc_word[osc_pkg::FAIL_BIT]          = fail_r;
		osc_word[osc_pkg::LPEN_BIT]          = lpen_r;
		osc_word[osc_pkg::SWEN_BIT]          = swen_r;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				osc_pkg::ADDR_OSC_CTRL: reg_rdata_o <= osc_word;
				osc_pkg::ADDR_CLK_DIV:  reg_rdata_o <= {5'h00, frc_post_r, pll_post_r, 1'b0, pll_pre_r};
				osc_pkg::ADDR_FB_DIV:   reg_rdata_o <= {7'h00, pll_fb_r};
				default:                reg_rdata_o <= 16'h0000;
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	assign pin_select_wr_ok_o    = pin_select_wr_i && !pinsel_r;
	assign ref_clk_o             = slow_internal_osc_s_r[1];
	assign active_source_o       = cur_src_r;
	assign active_submode_o      = submode_r;
	assign pll_prescale_code_o   = pll_pre_r;
	assign pll_multiplier_code_o = pll_fb_r;
	assign pll_postscale_code_o  = pll_post_r;

	chk_fail_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		fail_s_r[1] |=> fail_r) else $error("fail flag not set");
	chk_pinsel_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		pinsel_r |-> !pin_select_wr_ok_o) else $error("pin select write passed");
	chk_lock_nonpll: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!is_pll |=> !lock_r) else $error("lock high without pll");
	chk_rsvd_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == osc_pkg::ADDR_OSC_CTRL |=> (reg_rdata_o & 16'h8814) == 16'h0000)
		else $error("reserved bits nonzero");
	chk_freeze_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		freeze_r && !cfg_load_r |=> $stable(next_src_r)) else $error("source moved while frozen");
	chk_cfg_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		cfg_load_r |=> cur_src_r == $past(initial_source_select_i)) else $error("config not taken");
	chk_instr_half: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		instr_clk_en_o |-> osc_clk_en_o) else $error("instr tick without osc tick");
	chk_bypass_pll: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!is_pll |=> !pll_out_tick) else $error("pll active in non pll mode");

	localparam int SWITCH_WAIT = osc_pkg::SWITCH_SETTLE;
	sequence sw_begin;
		swen_r && settle_r == 4'h0 && next_src_r != cur_src_r;
	endsequence
	sequence sw_end;
		!swen_r && cur_src_r == next_src_r;
	endsequence
	chk_switch_settle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		sw_begin |-> ##SWITCH_WAIT sw_end) else $error("source switch did not complete");
endmodule
`default_nettype wire

// ==== core/osc_pkg.sv ====
`default_nettype none
package osc_pkg;
	// register indices on the plain register port
	localparam logic [1:0] ADDR_OSC_CTRL = 2'h0;
	localparam logic [1:0] ADDR_CLK_DIV  = 2'h1;
	localparam logic [1:0] ADDR_FB_DIV   = 2'h2;
	// oscillator_control fields
	localparam int CUR_SRC_LSB  = 12;
	localparam int NEXT_SRC_LSB = 8;
	localparam int FREEZE_BIT   = 7;
	localparam int PINSEL_BIT   = 6;
	localparam int LOCK_BIT     = 5;
	localparam int FAIL_BIT     = 3;
	localparam int LPEN_BIT     = 1;
	localparam int SWEN_BIT     = 0;
	// clock_divisor_reg fields
	localparam int FRCDIV_LSB   = 8;
	localparam int POSTDIV_LSB  = 6;
	localparam int PREDIV_LSB   = 0;
	// reset values
	localparam logic [2:0] FRC_POST_RST = 3'h0;
	localparam logic [1:0] PLL_POST_RST = 2'h1;
	localparam logic [4:0] PLL_PRE_RST  = 5'h00;
	localparam logic [8:0] PLL_FB_RST   = 9'h030;
	// sources
	typedef enum logic [2:0] {
		SRC_FRC     = 3'h0,
		SRC_FRC_PLL = 3'h1,
		SRC_PRI     = 3'h2,
		SRC_PRI_PLL = 3'h3,
		SRC_LPXTAL  = 3'h4,
		SRC_SLOW_INTERNAL_OSC    = 3'h5,
		SRC_FRC16   = 3'h6,
		SRC_FRCN    = 3'h7
	} src_e;
	localparam logic [1:0] SUB_EC = 2'h0;
	localparam logic [1:0] SUB_XT = 2'h1;
	localparam logic [1:0] SUB_HS = 2'h2;
	localparam logic [1:0] SWMON_SWITCH_ONLY = 2'h1;
	localparam logic [3:0] FRC16_SHIFT = 4'h4;
	localparam int         SWITCH_SETTLE   = 10;
	localparam int         LOCK_WAIT_US    = 2;
	localparam int         CLK_MHZ         = 50;
	localparam int         LOCK_WAIT_CYC   = LOCK_WAIT_US * CLK_MHZ;
endpackage
`default_nettype wire

// ==== test/osc_clk_model.sv ====
`default_nettype none
module osc_clk_model #(
	parameter real FRC_HALF  = 50.0,
	parameter real SLOW_HALF = 320.0,
	parameter real PRI_HALF  = 60.0,
	parameter real LPX_HALF  = 400.0
) (
	input  wire logic [4:0] pre_code_i,
	input  wire logic [8:0] mult_code_i,
	output logic            fast_o,
	output logic            slow_o,
	output logic            pri_o,
	output logic            lpx_o,
	output logic            vco_o
);
	timeunit 1ns;
	timeprecision 100ps;
	real vco_half;
	initial begin
		fast_o = 1'b0;
		slow_o = 1'b0;
		pri_o = 1'b0;
		lpx_o = 1'b0;
		vco_o = 1'b0;
	end
	always #(FRC_HALF) fast_o = ~fast_o;
	always #(SLOW_HALF) slow_o = ~slow_o;
	always #(PRI_HALF) pri_o = ~pri_o;
	always #(LPX_HALF) lpx_o = ~lpx_o;
	// vco rate from input times multiplier over prescale
	always_comb vco_half = FRC_HALF * (pre_code_i + 2) / (mult_code_i + 2);
	// clamped so that wild codes stay sampleable by the 2-flop sync
	always begin
		// unknown codes before reset give no valid period, so fall back to the clamp
		#(vco_half >= 30.0 ? vco_half : 30.0);
		vco_o = ~vco_o;
	end
endmodule
`default_nettype wire

// ==== test/osc_source_pll_select_bench.sv ====
`default_nettype none
module osc_source_pll_select_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LOCK_N = 4;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [2:0]  src_cfg = 3'h7;
	logic [1:0]  sub_cfg = 2'h0;
	logic [1:0]  swmon_cfg = 2'h3;
	logic        fail_in = 1'b0;
	logic [1:0]  addr = 2'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ps_wr = 1'b0;
	logic        rd_pend = 1'b0;
	logic [15:0] rdata;
	logic        ps_ok, instr_en, osc_en, ref_clk;
	logic        fast, slow, pri, lpx, vco;
	logic [2:0]  act_src;
	logic [1:0]  act_sub, post_code;
	logic [4:0]  pre_code;
	logic [8:0]  mult_code;
	logic [15:0] exp_q[$];
	logic [15:0] lfsr = 16'h0048;
	int          div_tab[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
	int          fail_count = 0;
	int          checked = 0;

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	osc_clk_model i_osc (.pre_code_i(pre_code), .mult_code_i(mult_code), .fast_o(fast),
		.slow_o(slow), .pri_o(pri), .lpx_o(lpx), .vco_o(vco));

	osc_source_pll_select #(.LOCK_CYCLES(LOCK_N)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.initial_source_select_i(src_cfg), .primary_submode_select_i(sub_cfg),
		.switch_monitor_config_i(swmon_cfg), .fast_internal_osc_i(fast),
		.slow_internal_osc_i(slow), .primary_osc_i(pri), .low_power_crystal_osc_i(lpx),
		.pll_vco_i(vco), .clock_fail_monitor_i(fail_in), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .pin_select_wr_i(ps_wr),
		.reg_rdata_o(rdata), .pin_select_wr_ok_o(ps_ok), .instr_clk_en_o(instr_en),
		.osc_clk_en_o(osc_en), .ref_clk_o(ref_clk), .active_source_o(act_src),
		.active_submode_o(act_sub), .pll_prescale_code_o(pre_code),
		.pll_multiplier_code_o(mult_code), .pll_postscale_code_o(post_code));

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_count(input int got, input int exp, input int tol);
		checked++;
		if (got < exp - tol || got > exp + tol) begin
			fail_count++;
			$display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [1:0] a, input logic [15:0] e);
		@(posedge clk_i);
		exp_q.push_back(e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk_i) begin
		rd_pend <= rd;
		if (rd_pend) begin
			cmp_word(rdata, exp_q.pop_front());
		end
	end

	task automatic do_reset(input logic [2:0] s, input logic [1:0] m);
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		src_cfg <= s;
		sub_cfg <= m;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic wait_src(input logic [2:0] s);
		int n;
		n = 0;
		while (act_src !== s && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		cmp_word({13'h0, act_src}, {13'h0, s});
		repeat (LOCK_N + 4) @(posedge clk_i);
	endtask

	task automatic chk_rate(input int w, input int exp_osc);
		int   n_osc;
		int   n_ins;
		int   n_ref;
		logic ref_d;
		n_osc = 0;
		n_ins = 0;
		n_ref = 0;
		ref_d = ref_clk;
		repeat (w) begin
			@(posedge clk_i);
			n_osc += int'(osc_en === 1'b1);
			n_ins += int'(instr_en === 1'b1);
			n_ref += int'(ref_clk === 1'b1 && ref_d === 1'b0);
			ref_d = ref_clk;
		end
		cmp_count(n_osc, exp_osc, 2);
		cmp_count(n_ins * 2, n_osc, 2);
		cmp_count(n_ref, w * 20 / 640, 2);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk_i);
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end

	initial begin
		logic [15:0] d;
		for (int s = 0; s < 9; s++) begin
			do_reset(3'(s == 8 ? 2 : s), 2'(s == 8 ? 1 : s % 3));
			cmp_word({13'h0, act_src}, 16'(s == 8 ? 2 : s));
			if (s == 2 || s == 3 || s == 8) begin
				cmp_word({14'h0, act_sub}, 16'(s == 8 ? 1 : s % 3));
			end
		end
		do_reset(3'h7, 2'h0);
		rd_reg(osc_pkg::ADDR_OSC_CTRL, 16'h7700);
		rd_reg(osc_pkg::ADDR_CLK_DIV, 16'h0040);
		rd_reg(osc_pkg::ADDR_FB_DIV, 16'h0030);
		wr_reg(2'h3, 16'hFFFF);
		rd_reg(2'h3, 16'h0000);
		wr_reg(osc_pkg::ADDR_OSC_CTRL, 16'h88D6);
		rd_reg(osc_pkg::ADDR_OSC_CTRL, 16'h77C2);
		ps_wr <= 1'b1;
		@(posedge clk_i);
		cmp_word({15'h0, ps_ok}, 16'h0000);
		wr_reg(osc_pkg::ADDR_OSC_CTRL, 16'h0000);
		@(posedge clk_i);
		cmp_word({15'h0, ps_ok}, 16'h0001);
		ps_wr <= 1'b0;
		repeat (4) begin
			lfsr = lfsr_next(lfsr);
			// bit 6 forced so the reserved output divider code never appears
			d = (lfsr & 16'h079F) | 16'h0040;
			wr_reg(osc_pkg::ADDR_CLK_DIV, d);
			rd_reg(osc_pkg::ADDR_CLK_DIV, d);
			cmp_word({11'h0, pre_code}, {11'h0, d[4:0]});
			cmp_word({14'h0, post_code}, {14'h0, d[7:6]});
			wr_reg(osc_pkg::ADDR_FB_DIV, lfsr);
			rd_reg(osc_pkg::ADDR_FB_DIV, {7'h00, lfsr[8:0]});
			cmp_word({7'h00, mult_code}, {7'h00, lfsr[8:0]});
		end
		fail_in <= 1'b1;
		repeat (5) @(posedge clk_i);
		fail_in <= 1'b0;
		repeat (5) @(posedge clk_i);
		rd_reg(osc_pkg::ADDR_OSC_CTRL, 16'h7708);
		wr_reg(osc_pkg::ADDR_OSC_CTRL, 16'h0000);
		rd_reg(osc_pkg::ADDR_OSC_CTRL, 16'h7700);
		foreach (div_tab[k]) begin
			wr_reg(osc_pkg::ADDR_CLK_DIV, {5'h00, 3'(k), 8'h40});
			chk_rate(3000, 600 / div_tab[k]);
		end
		swmon_cfg <= 2'h1;
		// model vco runs scaled down so the system clock can still sample it
		wr_reg(osc_pkg::ADDR_CLK_DIV, 16'h0000);
		wr_reg(osc_pkg::ADDR_FB_DIV, 16'h0000);
		wr_reg(osc_pkg::ADDR_OSC_CTRL, 16'h0101);
		wait_src(3'h1);
		rd_reg(osc_pkg::ADDR_OSC_CTRL, 16'h1120);
		chk_rate(2000, 200);
		wr_reg(osc_pkg::ADDR_OSC_CTRL, 16'h0180);
		wr_reg(osc_pkg::ADDR_OSC_CTRL, 16'h0580);
		rd_reg(osc_pkg::ADDR_OSC_CTRL, 16'h11A0);
		wr_reg(osc_pkg::ADDR_OSC_CTRL, 16'h0100);
		wr_reg(osc_pkg::ADDR_OSC_CTRL, 16'h0001);
		wait_src(3'h0);
		rd_reg(osc_pkg::ADDR_OSC_CTRL, 16'h0000);
		chk_rate(2000, 400);
		repeat (4) @(posedge clk_i);
		test_done();
	end
endmodule
`default_nettype wire
